// *** dv/scsi_peer.sv ***
`timescale 1ns/1ps

// Wide bus peer: takes words with random stalls, offers queued words
module scsi_peer (
  input  wire logic        clk_i,       // Core clock
  input  wire logic        tx_valid_i,  // Word offered by engine
  input  wire logic [15:0] tx_data_i,   // Word from engine
  output logic             tx_ready_o,  // Word taken
  output logic             rx_valid_o,  // Word offered to engine
  output logic      [15:0] rx_data_o,   // Word to engine
  input  wire logic        rx_ready_i   // Engine took word
);
  logic [15:0] words[$];
  logic [31:0] lf;
  logic        took;
  logic        v;

  // Queue a word for the next receive move
  task automatic give(input logic [15:0] w);
    words.push_back(w);
  endtask : give

  // Note at each rising edge whether a receive word was taken
  always @(posedge clk_i) begin
    took = rx_valid_o && rx_ready_i;
  end

  // Idle at time zero, then stall and offer words off the sampling edge
  initial begin
    lf = 32'h00001234;
    tx_ready_o = 1'b0;
    rx_valid_o = 1'b0;
    rx_data_o = 16'h0000;
    forever begin
      @(negedge clk_i);
      lf = lf ^ (lf << 13);
      lf = lf ^ (lf >> 17);
      lf = lf ^ (lf << 5);
      tx_ready_o = |lf[1:0];
      v = rx_valid_o && !took;
      if (took) void'(words.pop_front());
      if (!v && words.size() > 0 && lf[2]) begin
        v = 1'b1;
        rx_data_o = words[0];
      end else if (!v) begin
        rx_data_o = ~rx_data_o;  // Released lines invert each idle cycle, so they carry the stale word every second one
      end
      rx_valid_o = v;
    end
  end
endmodule : scsi_peer

// *** dv/wide_residue_bench.sv ***
`timescale 1ns/1ps

// Bench for the odd-byte residue engine
module wide_residue_bench;
  logic        sys_clk, resetn, start, chained, init, ph_in, clr_s, clr_r;
  logic [23:0] count;
  logic        rd_valid, rd_ready, wr_valid, wr_ready;
  logic        tx_valid, tx_ready, rx_valid, rx_ready;
  logic [7:0]  rd_data, wr_data, hold, m_slo, m_rhi;
  logic [15:0] tx_data, rx_data, latch;
  logic        busy, done, s_flag, r_flag, m_sflag, m_rflag;
  logic [31:0] seed, r, stall;
  logic [15:0] exp_tx[$];
  logic [7:0]  exp_wr[$];
  int          miscompares;
  int          checks_done;

  wide_residue u_wide_residue (.sys_clk_i(sys_clk), .resetn_i(resetn), .move_start_i(start),
    .chained_block_move_i(chained), .initiator_i(init), .phase_data_in_i(ph_in),
    .byte_count_i(count), .clr_send_flag_i(clr_s), .clr_recv_flag_i(clr_r),
    .mem_rd_valid_i(rd_valid), .mem_rd_data_i(rd_data), .mem_rd_ready_o(rd_ready),
    .scsi_tx_valid_o(tx_valid), .scsi_tx_data_o(tx_data), .scsi_tx_ready_i(tx_ready),
    .scsi_rx_valid_i(rx_valid), .scsi_rx_data_i(rx_data), .scsi_rx_ready_o(rx_ready),
    .mem_wr_valid_o(wr_valid), .mem_wr_data_o(wr_data), .mem_wr_ready_i(wr_ready),
    .busy_o(busy), .move_done_o(done), .send_residue_flag_o(s_flag),
    .receive_residue_flag_o(r_flag), .send_output_latch_o(latch),
    .receive_residue_hold_o(hold));

  scsi_peer u_scsi_peer (.clk_i(sys_clk), .tx_valid_i(tx_valid), .tx_data_i(tx_data),
    .tx_ready_o(tx_ready), .rx_valid_o(rx_valid), .rx_data_o(rx_data), .rx_ready_i(rx_ready));

  // Clock at 40 MHz
  always #12.5 sys_clk = ~sys_clk;

  // Xorshift source
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  task automatic end_sim();
    if (miscompares == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", name, e, g);
    end
  endtask : chk

  // Bounded wait at falling edges for a high level
  task automatic wait_hi(input logic on_done);
    for (int k = 0; k < 500 && (on_done ? done : rd_ready) !== 1'b1; k++) @(negedge sys_clk);
    if ((on_done ? done : rd_ready) !== 1'b1) begin
      miscompares++;
      end_sim();
    end
  endtask : wait_hi

  // Issue a move; role picked at random
  task automatic begin_move(input logic ch, input logic snd, input int n);
    @(negedge sys_clk);
    r = rnd();
    start = 1'b1;
    chained = ch;
    init = r[0];
    ph_in = r[0] ^ snd;
    count = 24'(n);
    @(negedge sys_clk);
    start = 1'b0;
    chk("busy_on", 16'h0001, 16'(busy));
  endtask : begin_move

  // Wait for the end and compare the residue state
  task automatic finish_move();
    wait_hi(1'b1);
    @(negedge sys_clk);
    chk("busy_off", 16'h0000, 16'(busy));
    chk("send_flag", 16'(m_sflag), 16'(s_flag));
    chk("recv_flag", 16'(m_rflag), 16'(r_flag));
    if (m_sflag) chk("latch_low", 16'(m_slo), 16'(latch[7:0]));
    if (m_rflag) chk("hold", 16'(m_rhi), 16'(hold));
    chk("left", 16'h0000, 16'(exp_tx.size() + exp_wr.size()));
  endtask : finish_move

  // Send move: memory bytes pair low then high
  task automatic do_send(input logic ch, input int n);
    logic       have;
    logic [7:0] lo;
    have = m_sflag;
    lo = m_slo;
    begin_move(ch, 1'b1, n);
    for (int i = 0; i < n; i++) begin
      r = rnd();
      if (have) exp_tx.push_back({r[7:0], lo});
      else lo = r[7:0];
      have = !have;
      rd_valid = 1'b1;
      rd_data = r[7:0];
      wait_hi(1'b0);
      @(negedge sys_clk);
    end
    rd_valid = 1'b0;
    rd_data = ~rd_data;
    if (have && ch) m_slo = lo;
    if (have && !ch) exp_tx.push_back({8'h00, lo});
    m_sflag = have & ch;
    finish_move();
  endtask : do_send

  // Receive move: words split low then high
  task automatic do_recv(input logic ch, input int n);
    int rem;
    rem = n;
    if (ch && m_rflag) begin
      exp_wr.push_back(m_rhi);
      rem--;
    end
    m_rflag = 1'b0;
    while (rem > 0) begin
      r = rnd();
      u_scsi_peer.give(r[15:0]);
      exp_wr.push_back(r[7:0]);
      rem--;
      if (rem > 0) begin
        exp_wr.push_back(r[15:8]);
        rem--;
      end else begin
        m_rflag = 1'b1;
        m_rhi = r[15:8];
      end
    end
    begin_move(ch, 1'b0, n);
    finish_move();
  endtask : do_recv

  // Explicit flag clear
  task automatic pulse_clear(input logic snd);
    @(negedge sys_clk);
    clr_s = snd;
    clr_r = !snd;
    @(negedge sys_clk);
    clr_s = 1'b0;
    clr_r = 1'b0;
    if (snd) chk("send_clr", 16'h0000, 16'(s_flag));
    else chk("recv_clr", 16'h0000, 16'(r_flag));
    if (snd) m_sflag = 1'b0;
    else m_rflag = 1'b0;
  endtask : pulse_clear

  // Scoreboard on bus words and memory writes
  always @(posedge sys_clk) begin
    if (resetn && tx_valid === 1'b1 && tx_ready === 1'b1) begin
      if (exp_tx.size() == 0) chk("tx_extra", 16'h0000, 16'h0001);
      else chk("tx_word", exp_tx.pop_front(), tx_data);
    end
    if (resetn && wr_valid === 1'b1 && wr_ready === 1'b1) begin
      if (exp_wr.size() == 0) chk("wr_extra", 16'h0000, 16'h0001);
      else chk("wr_byte", 16'(exp_wr.pop_front()), 16'(wr_data));
    end
  end

  // Memory write stalls
  always @(negedge sys_clk) begin
    stall = rnd();
    wr_ready = |stall[1:0];
  end

  // Main sequence
  initial begin
    {sys_clk, resetn, start, chained, init, ph_in, clr_s, clr_r} = 8'h00;
    {rd_valid, m_sflag, m_rflag} = 3'h0;
    {count, rd_data, m_slo, m_rhi} = 48'h000000000000;
    seed = 32'h0000001c;
    miscompares = 0;
    checks_done = 0;
    repeat (8) @(posedge sys_clk);
    @(negedge sys_clk);
    resetn = 1'b1;
    @(negedge sys_clk);
    chk("rst_flags", 16'h0000, 16'({s_flag, r_flag}));
    chk("rst_latch", 16'h0000, latch);
    chk("rst_hold", 16'h0000, 16'(hold));
    do_send(1'b1, 5);
    do_send(1'b0, 3);
    do_send(1'b0, 3);
    do_send(1'b1, 1);
    pulse_clear(1'b1);
    do_send(1'b0, 2);
    do_recv(1'b0, 3);
    do_recv(1'b1, 3);
    do_recv(1'b1, 2);
    do_recv(1'b0, 1);
    do_recv(1'b0, 2);
    do_recv(1'b0, 5);
    pulse_clear(1'b0);
    do_recv(1'b1, 2);
    for (int i = 0; i < 40; i++) begin
      r = rnd();
      if (r[0]) do_send(r[1], 1 + int'(r[4:2]));
      else do_recv(r[1], 1 + int'(r[4:2]));
    end
    end_sim();
  end
endmodule : wide_residue_bench

// *** logic/move_counter.sv ***
`timescale 1ns/1ps

// Memory-side byte counter of one move
module move_counter #(
  parameter int unsigned CW = residue_pkg::CNT_W
) (
  input  wire logic          sys_clk_i,  // Core clock
  input  wire logic          resetn_i,   // Async reset, low
  input  wire logic          load_i,     // Load new count
  input  wire logic [CW-1:0] value_i,    // Count to load
  input  wire logic          dec_i,      // One byte moved
  output logic      [CW-1:0] left_o      // Bytes still to move
);

  typedef struct packed {
    logic [CW-1:0] left;
  } cnt_s;

  cnt_s q_r;
  cnt_s q_nxt;

  // Load wins over decrement
  always_comb begin
    q_nxt = q_r;
    if (load_i) begin
      q_nxt.left = value_i;
    end else if (dec_i && (q_r.left != '0)) begin
      q_nxt.left = q_r.left - CW'(1);
    end
  end

  // State register
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign left_o = q_r.left;

endmodule : move_counter

// *** logic/residue_pkg.sv ***
package residue_pkg;

  // Data path widths
  localparam int unsigned BYTE_W  = 8;
  localparam int unsigned WORD_W  = 16;
  localparam int unsigned CNT_W   = 24;

  // Byte lanes of a wide bus word
  localparam int unsigned LO_LSB  = 0;
  localparam int unsigned HI_LSB  = 8;

  // Reset values and the pad byte
  localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;
  localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
  localparam logic [BYTE_W-1:0] PAD_BYTE = 8'h00;

  // Byte counts that steer the sequencer
  localparam logic [CNT_W-1:0]  CNT_ZERO = 24'h000000;
  localparam logic [CNT_W-1:0]  CNT_ONE  = 24'h000001;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_FETCH,
    ST_TX,
    ST_RX,
    ST_WR
  } seq_e;

endpackage : residue_pkg

// *** logic/wide_residue.sv ***
// Contract
// - Send is initiator Data Out or target Data In; receive is the opposite.
// - Send residue flag is set only by a chained send ending odd.
// - That trailing low byte stays in the send output latch, not sent.
// - A normal send sends its odd last low byte on the bus.
// - With send flag set, first memory byte is high, paired with held low.
// - Send flag clears when paired word leaves, or by explicit clear.
// - Send byte count counts memory bytes, including a held-back byte.
// - Any receive move ending odd sets the receive residue flag.
// - The unwritten high byte of that transfer stays in the hold register.
// - Receive flag clears at next receive start, or by explicit clear.
// - Chained receive with flag set writes held byte first, counted.
// - Chained receive with flag clear runs like a normal move.
// - Normal receive ignores the hold register whatever the flag.
`timescale 1ns/1ps

module wide_residue #(
  parameter int unsigned CW = residue_pkg::CNT_W
) (
  input  wire logic          sys_clk_i,          // Core clock
  input  wire logic          resetn_i,           // Async reset, low
  input  wire logic          move_start_i,       // Start a move, pulse
  input  wire logic          chained_block_move_i, // Move is chained
  input  wire logic          initiator_i,        // Initiator role
  input  wire logic          phase_data_in_i,    // Bus phase is Data In
  input  wire logic [CW-1:0] byte_count_i,       // Memory bytes to move
  input  wire logic          clr_send_flag_i,    // Clear send flag, pulse
  input  wire logic          clr_recv_flag_i,    // Clear receive flag, pulse
  input  wire logic          mem_rd_valid_i,     // Memory byte offered
  input  wire logic [7:0]    mem_rd_data_i,      // Memory byte
  output logic               mem_rd_ready_o,     // Memory byte taken
  output logic               scsi_tx_valid_o,    // Wide word to bus
  output logic [15:0]        scsi_tx_data_o,     // Word, low byte first
  input  wire logic          scsi_tx_ready_i,    // Bus took word
  input  wire logic          scsi_rx_valid_i,    // Wide word from bus
  input  wire logic [15:0]   scsi_rx_data_i,     // Received word
  output logic               scsi_rx_ready_o,    // Word taken
  output logic               mem_wr_valid_o,     // Byte to memory
  output logic [7:0]         mem_wr_data_o,      // Byte to memory
  input  wire logic          mem_wr_ready_i,     // Memory took byte
  output logic               busy_o,             // Move in progress
  output logic               move_done_o,        // Move ended, pulse
  output logic               send_residue_flag_o, // Send residue pending
  output logic               receive_residue_flag_o, // Receive residue
  output logic [15:0]        send_output_latch_o, // Send output latch
  output logic [7:0]         receive_residue_hold_o // Receive hold byte
);

  typedef struct packed {
    residue_pkg::seq_e st;
    logic              busy;
    logic              done;
    logic              chained;
    logic              send_flag;
    logic              recv_flag;
    logic              low_vld;
    logic              married;
    logic              rx_hi;
    logic [15:0]       latch;
    logic [7:0]        hold;
    logic              rd_rdy;
    logic              tx_vld;
    logic              rx_rdy;
    logic              wr_vld;
    logic [7:0]        wr_data;
  } res_s;

  res_s            q_r;
  res_s            q_nxt;
  logic            dir_send;
  logic            cnt_load;
  logic            cnt_dec;
  logic [CW-1:0]   left;

  // Direction from role and phase
  assign dir_send = initiator_i ^ phase_data_in_i;

  move_counter #(
    .CW (CW)
  ) u_cnt (
    .sys_clk_i (sys_clk_i),
    .resetn_i  (resetn_i),
    .load_i    (cnt_load),
    .value_i   (byte_count_i),
    .dec_i     (cnt_dec),
    .left_o    (left)
  );

  // Sequencer; hardware sets come after clears
  always_comb begin
    q_nxt    = q_r;
    cnt_load = 1'b0;
    cnt_dec  = 1'b0;
    q_nxt.done = 1'b0;
    if (clr_send_flag_i) begin
      q_nxt.send_flag = 1'b0;
    end
    if (clr_recv_flag_i) begin
      q_nxt.recv_flag = 1'b0;
    end
    unique case (q_r.st)
      residue_pkg::ST_IDLE: begin
        if (move_start_i) begin
          cnt_load      = 1'b1;
          q_nxt.chained = chained_block_move_i;
          q_nxt.busy    = 1'b1;
          q_nxt.rx_hi   = 1'b0;
          q_nxt.married = 1'b0;
          if (!dir_send) begin
            q_nxt.recv_flag = 1'b0;
          end
          if (byte_count_i == residue_pkg::CNT_ZERO) begin
            q_nxt.busy = 1'b0;
            q_nxt.done = 1'b1;
          end else if (dir_send) begin
            q_nxt.low_vld = q_r.send_flag;
            q_nxt.rd_rdy  = 1'b1;
            q_nxt.st      = residue_pkg::ST_FETCH;
          end else if (chained_block_move_i && q_r.recv_flag) begin
            q_nxt.wr_data = q_r.hold;
            q_nxt.wr_vld  = 1'b1;
            q_nxt.st      = residue_pkg::ST_WR;
          end else begin
            q_nxt.rx_rdy = 1'b1;
            q_nxt.st     = residue_pkg::ST_RX;
          end
        end
      end
      residue_pkg::ST_FETCH: begin
        if (mem_rd_valid_i) begin
          cnt_dec = 1'b1;
          if (q_r.low_vld) begin
            q_nxt.latch[residue_pkg::HI_LSB +: residue_pkg::BYTE_W] =
              mem_rd_data_i;
            q_nxt.married = q_r.send_flag;
            q_nxt.low_vld = 1'b0;
            q_nxt.tx_vld  = 1'b1;
            q_nxt.rd_rdy  = 1'b0;
            q_nxt.st      = residue_pkg::ST_TX;
          end else begin
            q_nxt.latch[residue_pkg::LO_LSB +: residue_pkg::BYTE_W] =
              mem_rd_data_i;
            q_nxt.low_vld = 1'b1;
            if (left == residue_pkg::CNT_ONE) begin
              q_nxt.rd_rdy = 1'b0;
              if (q_r.chained) begin
                q_nxt.send_flag = 1'b1;
                q_nxt.busy      = 1'b0;
                q_nxt.done      = 1'b1;
                q_nxt.st        = residue_pkg::ST_IDLE;
              end else begin
                q_nxt.latch[residue_pkg::HI_LSB +: residue_pkg::BYTE_W] =
                  residue_pkg::PAD_BYTE;
                q_nxt.low_vld = 1'b0;
                q_nxt.tx_vld  = 1'b1;
                q_nxt.st      = residue_pkg::ST_TX;
              end
            end
          end
        end
      end
      residue_pkg::ST_TX: begin
        if (scsi_tx_ready_i) begin
          q_nxt.tx_vld = 1'b0;
          if (q_r.married) begin
            q_nxt.send_flag = 1'b0;
            q_nxt.married   = 1'b0;
          end
          if (left == residue_pkg::CNT_ZERO) begin
            q_nxt.busy = 1'b0;
            q_nxt.done = 1'b1;
            q_nxt.st   = residue_pkg::ST_IDLE;
          end else begin
            q_nxt.rd_rdy = 1'b1;
            q_nxt.st     = residue_pkg::ST_FETCH;
          end
        end
      end
      residue_pkg::ST_RX: begin
        if (scsi_rx_valid_i) begin
          q_nxt.hold = scsi_rx_data_i[residue_pkg::HI_LSB +:
                                      residue_pkg::BYTE_W];
          q_nxt.wr_data = scsi_rx_data_i[residue_pkg::LO_LSB +:
                                         residue_pkg::BYTE_W];
          q_nxt.rx_hi  = 1'b1;
          q_nxt.rx_rdy = 1'b0;
          q_nxt.wr_vld = 1'b1;
          q_nxt.st     = residue_pkg::ST_WR;
        end
      end
      residue_pkg::ST_WR: begin
        if (mem_wr_ready_i) begin
          cnt_dec      = 1'b1;
          q_nxt.wr_vld = 1'b0;
          if (left == residue_pkg::CNT_ONE) begin
            if (q_r.rx_hi) begin
              q_nxt.recv_flag = 1'b1;
              q_nxt.rx_hi     = 1'b0;
            end
            q_nxt.busy = 1'b0;
            q_nxt.done = 1'b1;
            q_nxt.st   = residue_pkg::ST_IDLE;
          end else if (q_r.rx_hi) begin
            q_nxt.wr_data = q_r.hold;
            q_nxt.wr_vld  = 1'b1;
            q_nxt.rx_hi   = 1'b0;
          end else begin
            q_nxt.rx_rdy = 1'b1;
            q_nxt.st     = residue_pkg::ST_RX;
          end
        end
      end
    endcase
  end

  // State register, flags and holds empty at reset
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q_r           <= '0;
      q_r.st        <= residue_pkg::ST_IDLE;
      q_r.latch     <= residue_pkg::WORD_RST;
      q_r.hold      <= residue_pkg::BYTE_RST;
      q_r.wr_data   <= residue_pkg::BYTE_RST;
    end else begin
      q_r <= q_nxt;
    end
  end

  // Outputs straight from the state register
  assign mem_rd_ready_o         = q_r.rd_rdy;
  assign scsi_tx_valid_o        = q_r.tx_vld;
  assign scsi_tx_data_o         = q_r.latch;
  assign scsi_rx_ready_o        = q_r.rx_rdy;
  assign mem_wr_valid_o         = q_r.wr_vld;
  assign mem_wr_data_o          = q_r.wr_data;
  assign busy_o                 = q_r.busy;
  assign move_done_o            = q_r.done;
  assign send_residue_flag_o    = q_r.send_flag;
  assign receive_residue_flag_o = q_r.recv_flag;
  assign send_output_latch_o    = q_r.latch;
  assign receive_residue_hold_o = q_r.hold;

  // Shorthand terms for the checks
  logic start_ok;
  logic fetch_tk;
  logic wr_tk;
  assign start_ok = move_start_i && (q_r.st == residue_pkg::ST_IDLE) &&
                    (byte_count_i != residue_pkg::CNT_ZERO);
  assign fetch_tk = (q_r.st == residue_pkg::ST_FETCH) && mem_rd_valid_i;
  assign wr_tk    = (q_r.st == residue_pkg::ST_WR) && mem_wr_ready_i;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);

  a_send_direction: assert property (
    start_ok && dir_send |=> mem_rd_ready_o && !scsi_rx_ready_o)
    else $error("send move did not start fetching");

  a_chained_only: assert property (
    $rose(send_residue_flag_o) |-> q_r.chained && $past(fetch_tk))
    else $error("send flag set outside chained end");

  a_low_withheld: assert property (
    $rose(send_residue_flag_o) |-> move_done_o && !scsi_tx_valid_o)
    else $error("held low byte was sent");

  a_normal_last: assert property (
    fetch_tk && !q_r.low_vld && (left == residue_pkg::CNT_ONE) &&
    !q_r.chained |=> scsi_tx_valid_o &&
    (send_output_latch_o[7:0] == $past(mem_rd_data_i)))
    else $error("normal send dropped last byte");

  a_married_word: assert property (
    fetch_tk && q_r.low_vld |=> scsi_tx_valid_o &&
    (scsi_tx_data_o[15:8] == $past(mem_rd_data_i)) &&
    (scsi_tx_data_o[7:0] == $past(send_output_latch_o[7:0])))
    else $error("pairing with held byte wrong");

  a_send_clear: assert property (
    (q_r.st == residue_pkg::ST_TX) && scsi_tx_ready_i && q_r.married
    |=> !send_residue_flag_o)
    else $error("send flag not cleared after pair");

  a_count_end: assert property (
    fetch_tk && (left == residue_pkg::CNT_ONE) |=> !mem_rd_ready_o)
    else $error("fetched beyond byte count");

  a_recv_set: assert property (
    wr_tk && (left == residue_pkg::CNT_ONE) && q_r.rx_hi
    |=> receive_residue_flag_o && move_done_o)
    else $error("receive flag not set on odd end");

  a_recv_hold: assert property (
    (q_r.st == residue_pkg::ST_RX) && scsi_rx_valid_i
    |=> (receive_residue_hold_o == $past(scsi_rx_data_i[15:8])) &&
    (mem_wr_data_o == $past(scsi_rx_data_i[7:0])))
    else $error("received word split wrong");

  a_recv_clear: assert property (
    start_ok && !dir_send && !(q_r.recv_flag && chained_block_move_i)
    |=> !receive_residue_flag_o)
    else $error("receive flag kept at start");

  a_hold_first: assert property (
    start_ok && !dir_send && chained_block_move_i && q_r.recv_flag
    |=> mem_wr_valid_o && (mem_wr_data_o == $past(q_r.hold)) ##0
    !receive_residue_flag_o)
    else $error("held byte not written first");

  a_plain_recv: assert property (
    start_ok && !dir_send && !(chained_block_move_i && q_r.recv_flag)
    |=> scsi_rx_ready_o && !mem_wr_valid_o)
    else $error("plain receive touched hold byte");

  c_chained_send: cover property (
    $rose(send_residue_flag_o));
  c_married_out: cover property (
    (q_r.st == residue_pkg::ST_TX) && q_r.married && scsi_tx_ready_i);
  c_recv_odd: cover property (
    $rose(receive_residue_flag_o));
  c_hold_reuse: cover property (
    start_ok && !dir_send && chained_block_move_i && q_r.recv_flag);

endmodule : wide_residue
